// ==== hw/ihc_top.sv ====
// interrupt gathering and halt wake-up control with apb registers
`timescale 1ns/1ps
`default_nettype none
module ihc_top
   import ihc_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // event sources
   input wire ihc_event_s events,
   input wire logic [3:0] key_group_a_pins,
   input wire logic [3:0] key_group_b_pins,
   input wire logic key_single_pin,
   input wire logic [8:0] key_select,
   input wire logic [8:0] key_compare,
   input wire logic [3:0] tick_taps,
   // core handshake
   input wire ihc_core_s core,
   output logic irq_req,
   output logic [3:0] irq_vector,
   output logic irq_nmi,
   output logic cpu_halted
);
   // ----------------------------------------------------------------
   // register map helpers
   // ----------------------------------------------------------------
   // spreads a 4-bit register value onto the source vector
   function automatic logic [IHC_NSRC-1:0] spread(input logic [15:0] idx, input logic [3:0] d);
      logic [IHC_NSRC-1:0] v;
      v = '0;
      unique case (idx)
         IHC_IDX_TIMER_MASK, IHC_IDX_TIMER_FLAG: v[IHC_POS_TIMER +: 2] = d[1:0];
         IHC_IDX_SERIAL_MASK, IHC_IDX_SERIAL_FLAG: v[IHC_POS_SERIAL] = d[0];
         IHC_IDX_KEYA_MASK, IHC_IDX_KEYA_FLAG: v[IHC_POS_KEYA] = d[0];
         IHC_IDX_KEYBC_MASK, IHC_IDX_KEYBC_FLAG: v[IHC_POS_KEYB +: 2] = d[1:0];
         IHC_IDX_TICK_MASK, IHC_IDX_TICK_FLAG: v[IHC_POS_TICK +: 4] = d;
         IHC_IDX_CONV_MASK, IHC_IDX_CONV_FLAG: v[IHC_POS_CONV] = d[0];
         default: v = '0;
      endcase
      return v;
   endfunction

   // gathers one register's bits; unused bits read as zero
   function automatic logic [3:0] gather(input logic [15:0] idx, input logic [IHC_NSRC-1:0] v);
      logic [3:0] r;
      r = 4'h0;
      unique case (idx)
         IHC_IDX_TIMER_MASK, IHC_IDX_TIMER_FLAG: r[1:0] = v[IHC_POS_TIMER +: 2];
         IHC_IDX_SERIAL_MASK, IHC_IDX_SERIAL_FLAG: r[0] = v[IHC_POS_SERIAL];
         IHC_IDX_KEYA_MASK, IHC_IDX_KEYA_FLAG: r[0] = v[IHC_POS_KEYA];
         IHC_IDX_KEYBC_MASK, IHC_IDX_KEYBC_FLAG: r[1:0] = v[IHC_POS_KEYB +: 2];
         IHC_IDX_TICK_MASK, IHC_IDX_TICK_FLAG: r = v[IHC_POS_TICK +: 4];
         IHC_IDX_CONV_MASK, IHC_IDX_CONV_FLAG: r[0] = v[IHC_POS_CONV];
         default: r = 4'h0;
      endcase
      return r;
   endfunction

   function automatic logic is_mask(input logic [15:0] idx);
      return idx >= IHC_IDX_TIMER_MASK && idx <= IHC_IDX_CONV_MASK;
   endfunction

   function automatic logic is_flag(input logic [15:0] idx);
      return idx >= IHC_IDX_TIMER_FLAG && idx <= IHC_IDX_CONV_FLAG;
   endfunction

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [IHC_NSRC-1:0] flags_q;
   logic [IHC_NSRC-1:0] masks_q;
   logic [IHC_NSRC-1:0] set_ev;
   logic [IHC_NSRC-1:0] clr_w1c;
   logic [8:0] key_pins;
   logic [8:0] key_prev_q;
   logic [8:0] key_hit;
   logic key_armed_q;
   logic [3:0] tick_prev_q;
   logic gie_q;
   logic sp_ok_q;
   logic sp1_pend_q;
   logic sp2_pend_q;
   logic nmi_pend_q;
   logic halted_q;
   logic [3:0] vector_q;
   logic nmi_sel_q;
   logic [31:0] rdata_q;
   logic [15:0] idx;
   logic addr_ok;
   logic wr_acc;
   logic [IHC_NSRC-1:0] pend;
   logic nmi_live;
   logic mask_live;
   logic [3:0] vec_d;
   logic accept;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   assign idx = paddr[17:2];
   assign addr_ok = (paddr[31:18] == '0) && (paddr[1:0] == 2'b00) &&
      (is_mask(idx) || is_flag(idx) || idx == IHC_IDX_CORE_CTRL);
   assign wr_acc = psel && penable && pwrite && addr_ok && pstrb[0];
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;
   assign prdata = rdata_q;

   // read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= '0;
      end else if (psel && !penable && !pwrite) begin
         if (!addr_ok) begin
            rdata_q <= '0;
         end else if (idx == IHC_IDX_CORE_CTRL) begin
            rdata_q <= {28'h0, nmi_pend_q, halted_q, sp_ok_q, gie_q};
         end else if (is_mask(idx)) begin
            rdata_q <= {28'h0, gather(idx, masks_q)};
         end else begin
            rdata_q <= {28'h0, gather(idx, flags_q)};
         end
      end
   end

   // ----------------------------------------------------------------
   // event detection
   // ----------------------------------------------------------------
   assign key_pins = {key_single_pin, key_group_b_pins, key_group_a_pins};
   // selected pin leaves its compare level; no edge on the first cycle after reset
   assign key_hit = key_select & (key_pins ^ key_prev_q) & ~(key_prev_q ^ key_compare) &
      {9{key_armed_q}};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_prev_q <= '0;
         tick_prev_q <= '0;
         key_armed_q <= 1'b0;
      end else begin
         key_prev_q <= key_pins;
         key_armed_q <= 1'b1;
         tick_prev_q <= tick_taps;
      end
   end

   always_comb begin
      set_ev = '0;
      set_ev[IHC_POS_TIMER +: 2] = events.timer_zero;
      set_ev[IHC_POS_SERIAL] = events.serial_done;
      set_ev[IHC_POS_KEYA] = |key_hit[3:0];
      set_ev[IHC_POS_KEYB] = |key_hit[7:4];
      set_ev[IHC_POS_KEYS] = key_hit[8];
      set_ev[IHC_POS_TICK +: 4] = tick_prev_q & ~tick_taps;
      set_ev[IHC_POS_CONV] = events.converter_done;
   end

   // ----------------------------------------------------------------
   // factor flags and masks
   // ----------------------------------------------------------------
   assign clr_w1c = (wr_acc && is_flag(idx)) ? spread(idx, pwdata[3:0]) : '0;

   // set wins over a simultaneous clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_q <= IHC_SRC_RESET;
      end else begin
         flags_q <= (flags_q & ~clr_w1c) | set_ev;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         masks_q <= IHC_SRC_RESET;
      end else if (wr_acc && is_mask(idx)) begin
         masks_q <= (masks_q & ~spread(idx, 4'hf)) | spread(idx, pwdata[3:0]);
      end
   end

   // ----------------------------------------------------------------
   // stack pointer pairing
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_ok_q <= 1'b0;
         sp1_pend_q <= 1'b0;
         sp2_pend_q <= 1'b0;
      end else if (core.first_stack_pointer_wr && core.second_stack_pointer_wr) begin
         sp_ok_q <= 1'b1;
         sp1_pend_q <= 1'b0;
         sp2_pend_q <= 1'b0;
      end else if (core.first_stack_pointer_wr) begin
         sp_ok_q <= sp2_pend_q;
         sp1_pend_q <= !sp2_pend_q;
         sp2_pend_q <= 1'b0;
      end else if (core.second_stack_pointer_wr) begin
         sp_ok_q <= sp1_pend_q;
         sp2_pend_q <= !sp1_pend_q;
         sp1_pend_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // request, priority and vector
   // ----------------------------------------------------------------
   assign pend = flags_q & masks_q;
   assign nmi_live = nmi_pend_q && sp_ok_q;
   assign mask_live = (|pend) && gie_q && sp_ok_q;
   assign irq_req = nmi_live || mask_live;
   assign accept = core.irq_ack && irq_req;

   always_comb begin
      if (nmi_live) begin
         vec_d = IHC_VEC_WDT;
      end else if (|pend[IHC_POS_TIMER +: 2]) begin
         vec_d = IHC_VEC_TIMER;
      end else if (pend[IHC_POS_SERIAL]) begin
         vec_d = IHC_VEC_SERIAL;
      end else if (pend[IHC_POS_KEYA]) begin
         vec_d = IHC_VEC_KEYA;
      end else if (|pend[IHC_POS_KEYB +: 2]) begin
         vec_d = IHC_VEC_KEYBC;
      end else if (|pend[IHC_POS_TICK +: 4]) begin
         vec_d = IHC_VEC_TICK;
      end else begin
         vec_d = IHC_VEC_CONV;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vector_q <= IHC_VEC_WDT;
         nmi_sel_q <= 1'b0;
      end else begin
         vector_q <= vec_d;
         nmi_sel_q <= nmi_live;
      end
   end

   assign irq_vector = vector_q;
   assign irq_nmi = nmi_sel_q;

   // watchdog request held until accepted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_pend_q <= 1'b0;
      end else if (events.watchdog) begin
         nmi_pend_q <= 1'b1;
      end else if (accept && nmi_live) begin
         nmi_pend_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // global enable flag
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gie_q <= 1'b0;
      end else if (accept || core.disable_irq) begin
         gie_q <= 1'b0;
      end else if (core.enable_irq) begin
         gie_q <= 1'b1;
      end else if (wr_acc && idx == IHC_IDX_CORE_CTRL) begin
         gie_q <= pwdata[IHC_CTRL_GIE];
      end
   end

   // ----------------------------------------------------------------
   // halt control
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halted_q <= 1'b0;
      end else if (irq_req) begin
         halted_q <= 1'b0;
      end else if (core.halt_exec) begin
         halted_q <= 1'b1;
      end
   end

   assign cpu_halted = halted_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_accept;
      core.irq_ack && irq_req;
   endsequence

   sequence s_flag_write(int unsigned bitpos);
      wr_acc && idx == IHC_IDX_SERIAL_FLAG && pwdata[bitpos] && !events.serial_done;
   endsequence

   AST_BLOCK_BEFORE_SP: assert property (@(posedge pclk) disable iff (!presetn)
      !sp_ok_q |-> !irq_req)
      else $error("request raised before both stack pointers written");

   AST_SINGLE_SP_BLOCKS: assert property (@(posedge pclk) disable iff (!presetn)
      (core.first_stack_pointer_wr && !core.second_stack_pointer_wr && !sp2_pend_q)
      |=> !sp_ok_q && !irq_req)
      else $error("single stack pointer write did not block requests");

   AST_ACCEPT_CLEARS_GIE: assert property (@(posedge pclk) disable iff (!presetn)
      s_accept |=> !gie_q)
      else $error("global enable still set after acceptance");

   AST_MASKABLE_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
      irq_req && !nmi_pend_q |-> gie_q && (|(flags_q & masks_q)))
      else $error("maskable request without flag, mask and enable");

   AST_NMI_IGNORES_GIE: assert property (@(posedge pclk) disable iff (!presetn)
      events.watchdog && sp_ok_q && !gie_q |=> irq_req ##1 irq_vector == IHC_VEC_WDT)
      else $error("watchdog request not delivered with enable clear");

   AST_LEVEL_REQ: assert property (@(posedge pclk) disable iff (!presetn)
      (gie_q && sp_ok_q && (|(flags_q & masks_q))) [*2] |-> irq_req)
      else $error("pending enabled flag dropped its request");

   AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
      events.timer_zero[0] |=> flags_q[IHC_POS_TIMER])
      else $error("timer flag not set on its event");

   AST_W1C: assert property (@(posedge pclk) disable iff (!presetn)
      s_flag_write(0) |=> !flags_q[IHC_POS_SERIAL])
      else $error("write one did not clear the serial flag");

   AST_TICK_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(tick_taps[3]) |=> flags_q[IHC_POS_TICK + 3])
      else $error("1 hz flag not set on falling edge");

   AST_HALT_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
      core.halt_exec && !irq_req |=> cpu_halted)
      else $error("halt not entered");

   AST_HALT_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
      cpu_halted && irq_req |=> !cpu_halted)
      else $error("request did not release halt");

   AST_PRIORITY: assert property (@(posedge pclk) disable iff (!presetn)
      !nmi_live && pend[IHC_POS_TIMER + 1] && pend[IHC_POS_CONV] |=> irq_vector == IHC_VEC_TIMER)
      else $error("lower priority vector presented");

   AST_RESET_MASK: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> masks_q == '0 && flags_q == '0)
      else $error("masks or flags not clear after reset");
endmodule
`default_nettype wire

// ==== pkg/ihc_pkg.sv ====
// constants and carrier types of the interrupt and halt control block
package ihc_pkg;
   // ----------------------------------------------------------------
   // register indices; byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [15:0] IHC_IDX_CORE_CTRL = 16'hffe0;
   localparam logic [15:0] IHC_IDX_TIMER_MASK = 16'hffe2;
   localparam logic [15:0] IHC_IDX_SERIAL_MASK = 16'hffe3;
   localparam logic [15:0] IHC_IDX_KEYA_MASK = 16'hffe4;
   localparam logic [15:0] IHC_IDX_KEYBC_MASK = 16'hffe5;
   localparam logic [15:0] IHC_IDX_TICK_MASK = 16'hffe6;
   localparam logic [15:0] IHC_IDX_CONV_MASK = 16'hffe7;
   localparam logic [15:0] IHC_IDX_TIMER_FLAG = 16'hfff2;
   localparam logic [15:0] IHC_IDX_SERIAL_FLAG = 16'hfff3;
   localparam logic [15:0] IHC_IDX_KEYA_FLAG = 16'hfff4;
   localparam logic [15:0] IHC_IDX_KEYBC_FLAG = 16'hfff5;
   localparam logic [15:0] IHC_IDX_TICK_FLAG = 16'hfff6;
   localparam logic [15:0] IHC_IDX_CONV_FLAG = 16'hfff7;
   // ----------------------------------------------------------------
   // positions in the 11-bit source vector
   // ----------------------------------------------------------------
   localparam int IHC_NSRC = 11;
   localparam int IHC_POS_TIMER = 0;
   localparam int IHC_POS_SERIAL = 2;
   localparam int IHC_POS_KEYA = 3;
   localparam int IHC_POS_KEYB = 4;
   localparam int IHC_POS_KEYS = 5;
   localparam int IHC_POS_TICK = 6;
   localparam int IHC_POS_CONV = 10;
   // core control register bits
   localparam int IHC_CTRL_GIE = 0;
   localparam int IHC_CTRL_SPOK = 1;
   localparam int IHC_CTRL_HALT = 2;
   localparam int IHC_CTRL_NMI = 3;
   // ----------------------------------------------------------------
   // reset values and vector low nibbles
   // ----------------------------------------------------------------
   localparam logic [IHC_NSRC-1:0] IHC_SRC_RESET = 11'h000;
   localparam logic [3:0] IHC_VEC_WDT = 4'h0;
   localparam logic [3:0] IHC_VEC_TIMER = 4'h4;
   localparam logic [3:0] IHC_VEC_SERIAL = 4'h6;
   localparam logic [3:0] IHC_VEC_KEYA = 4'h8;
   localparam logic [3:0] IHC_VEC_KEYBC = 4'ha;
   localparam logic [3:0] IHC_VEC_TICK = 4'hc;
   localparam logic [3:0] IHC_VEC_CONV = 4'he;
   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] timer_zero;
      logic serial_done;
      logic converter_done;
      logic watchdog;
   } ihc_event_s;
   typedef struct packed {
      logic irq_ack;
      logic enable_irq;
      logic disable_irq;
      logic first_stack_pointer_wr;
      logic second_stack_pointer_wr;
      logic halt_exec;
   } ihc_core_s;
endpackage

// ==== sim/ihc_core_model.sv ====
// behavioural cpu core that takes requests and records them
`timescale 1ns/1ps
`default_nettype none
module ihc_core_model
   import ihc_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // from the block
   input wire logic irq_req,
   input wire logic [3:0] irq_vector,
   input wire logic irq_nmi,
   // bench commands
   input wire logic ack_en,
   input wire ihc_core_s cmd,
   // to the block and the bench
   output ihc_core_s core,
   output logic [7:0] taken,
   output logic [3:0] last_vec,
   output logic last_nmi
);
   logic seen_q;
   logic ack_q;
   // ------------------------------------------------------------
   // acceptance after two request cycles, vector settled by then
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen_q <= 1'b0;
         ack_q <= 1'b0;
         taken <= 8'h00;
         last_vec <= 4'h0;
         last_nmi <= 1'b0;
      end else begin
         seen_q <= irq_req;
         ack_q <= ack_en & irq_req & seen_q & ~ack_q;
         if (ack_q && irq_req) begin
            taken <= taken + 8'h01;
            last_vec <= irq_vector;
            last_nmi <= irq_nmi;
         end
      end
   end
   always_comb begin
      core = cmd;
      core.irq_ack = ack_q;
   end
endmodule
`default_nettype wire

// ==== sim/ihc_top_tb_top.sv ====
// self-checking bench of the interrupt and halt control block
`timescale 1ns/1ps
`default_nettype none
module ihc_top_tb_top
   import ihc_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready, pslverr, irq_req, irq_nmi, cpu_halted, last_nmi, err;
   ihc_event_s ev = '0;
   logic [3:0] kpa = 4'h0;
   logic [3:0] kpb = 4'h0;
   logic kps = 1'b1;
   logic [8:0] ksel = 9'h111;
   logic [8:0] kcmp = 9'h100;
   logic [3:0] taps = 4'h8;
   ihc_core_s cmd = '0;
   ihc_core_s core;
   logic ack_en = 1'b0;
   logic [3:0] irq_vector, last_vec;
   logic [7:0] taken;
   logic [31:0] rd;
   int bad_count = 0;
   int tests_run = 0;
   int cyc = 0;
   always #20 pclk = ~pclk;
   ihc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .events(ev), .key_group_a_pins(kpa),
      .key_group_b_pins(kpb), .key_single_pin(kps), .key_select(ksel), .key_compare(kcmp),
      .tick_taps(taps), .core(core), .irq_req(irq_req), .irq_vector(irq_vector),
      .irq_nmi(irq_nmi), .cpu_halted(cpu_halted));
   ihc_core_model core_m (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
      .irq_vector(irq_vector), .irq_nmi(irq_nmi), .ack_en(ack_en), .cmd(cmd), .core(core),
      .taken(taken), .last_vec(last_vec), .last_nmi(last_nmi));
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [3:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {14'h0, idx, 2'b00};
      pwdata <= {28'h0, wd};
      pstrb <= 4'hf;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   // event bits: timer one, timer zero, serial, converter, watchdog
   task automatic pulse_ev(input ihc_event_s e);
      @(posedge pclk);
      ev <= e;
      @(posedge pclk);
      ev <= '0;
   endtask
   // command bits: ack, ei, di, first sp, second sp, halt
   task automatic pulse_cmd(input ihc_core_s c);
      @(posedge pclk);
      cmd <= c;
      @(posedge pclk);
      cmd <= '0;
   endtask
   task automatic set_ack(input logic v);
      @(posedge pclk);
      ack_en <= v;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, IHC_IDX_TIMER_MASK + 16'(i), 4'h0);
         chk("mask reset", rd, 32'h0);
         apb(1'b0, IHC_IDX_TIMER_FLAG + 16'(i), 4'h0);
         chk("flag reset", rd, 32'h0);
      end
      apb(1'b0, 16'hffe1, 4'h0);
      chk("unmapped err", 32'(err), 32'h1);
   endtask
   task automatic t_masks;
      logic [3:0] w [6] = '{4'h3, 4'h1, 4'h1, 4'h3, 4'hf, 4'h1};
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, IHC_IDX_TIMER_MASK + 16'(i), 4'hf);
         apb(1'b0, IHC_IDX_TIMER_MASK + 16'(i), 4'h0);
         chk("mask set", rd, {28'h0, w[i]});
         apb(1'b1, IHC_IDX_TIMER_MASK + 16'(i), 4'h0);
         apb(1'b0, IHC_IDX_TIMER_MASK + 16'(i), 4'h0);
         chk("mask clear", rd, 32'h0);
      end
   endtask
   task automatic t_stack;
      set_ack(1'b1);
      pulse_cmd(6'b010000);
      apb(1'b1, IHC_IDX_TIMER_MASK, 4'h1);
      pulse_ev(5'b01000);
      pulse_ev(5'b00001);
      pulse_cmd(6'b000100);
      wait_n(6);
      chk("blocked req", 32'(irq_req), 32'h0);
      chk("blocked take", 32'(taken), 32'h0);
      pulse_cmd(6'b000010);
      wait_n(10);
      chk("nmi taken", 32'(taken), 32'h1);
      chk("nmi vector", 32'(last_vec), 32'(IHC_VEC_WDT));
      chk("nmi mark", 32'(last_nmi), 32'h1);
      apb(1'b0, IHC_IDX_CORE_CTRL, 4'h0);
      chk("enable after take", rd & 32'h1, 32'h0);
      apb(1'b0, IHC_IDX_TIMER_FLAG, 4'h0);
      chk("timer flag", rd, 32'h1);
      for (int k = 2; k < 4; k++) begin
         pulse_cmd(6'b010000);
         wait_n(10);
         chk("retaken", 32'(taken), 32'(k));
      end
      chk("timer vector", 32'(last_vec), 32'(IHC_VEC_TIMER));
      chk("timer mark", 32'(last_nmi), 32'h0);
      apb(1'b1, IHC_IDX_TIMER_FLAG, 4'h1);
      apb(1'b0, IHC_IDX_TIMER_FLAG, 4'h0);
      chk("flag cleared", rd, 32'h0);
      pulse_cmd(6'b010000);
      wait_n(10);
      chk("no retake", 32'(taken), 32'h3);
   endtask
   task automatic t_halt;
      pulse_cmd(6'b001000);
      pulse_cmd(6'b000001);
      wait_n(2);
      chk("halted", 32'(cpu_halted), 32'h1);
      pulse_ev(5'b01000);
      wait_n(4);
      chk("still halted", 32'(cpu_halted), 32'h1);
      apb(1'b0, IHC_IDX_TIMER_FLAG, 4'h0);
      chk("flag in halt", rd, 32'h1);
      pulse_ev(5'b00001);
      wait_n(8);
      chk("nmi wake", 32'(cpu_halted), 32'h0);
      chk("nmi no enable", 32'(taken), 32'h4);
      pulse_cmd(6'b000001);
      wait_n(2);
      chk("halted again", 32'(cpu_halted), 32'h1);
      pulse_cmd(6'b010000);
      wait_n(8);
      chk("irq wake", 32'(cpu_halted), 32'h0);
      chk("irq taken", 32'(taken), 32'h5);
      apb(1'b1, IHC_IDX_TIMER_FLAG, 4'h1);
      apb(1'b1, IHC_IDX_TIMER_MASK, 4'h0);
   endtask
   task automatic t_prio;
      logic [3:0] bits [6] = '{4'h2, 4'h1, 4'h1, 4'h3, 4'h8, 4'h1};
      logic [3:0] vec [6] = '{IHC_VEC_TIMER, IHC_VEC_SERIAL, IHC_VEC_KEYA, IHC_VEC_KEYBC,
         IHC_VEC_TICK, IHC_VEC_CONV};
      set_ack(1'b0);
      pulse_ev(5'b00100);
      pulse_cmd(6'b010000);
      wait_n(3);
      chk("masked req", 32'(irq_req), 32'h0);
      apb(1'b1, IHC_IDX_SERIAL_MASK, 4'h1);
      wait_n(3);
      chk("unmasked req", 32'(irq_req), 32'h1);
      pulse_cmd(6'b001000);
      wait_n(2);
      chk("disabled req", 32'(irq_req), 32'h0);
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, IHC_IDX_TIMER_MASK + 16'(i), 4'hf);
      end
      pulse_ev(5'b10010);
      @(posedge pclk);
      kpa <= 4'h1;
      kpb <= 4'h1;
      kps <= 1'b0;
      taps <= 4'h0;
      pulse_cmd(6'b010000);
      for (int i = 0; i < 6; i++) begin
         wait_n(3);
         apb(1'b0, IHC_IDX_TIMER_FLAG + 16'(i), 4'h0);
         chk("pending flag", rd, {28'h0, bits[i]});
         chk("vector", 32'(irq_vector), 32'(vec[i]));
         apb(1'b1, IHC_IDX_TIMER_FLAG + 16'(i), bits[i]);
      end
      wait_n(3);
      chk("all served", 32'(irq_req), 32'h0);
   endtask
   task automatic t_pair;
      set_ack(1'b1);
      pulse_cmd(6'b000010);
      pulse_ev(5'b00001);
      wait_n(6);
      chk("lone pointer", 32'(taken), 32'h5);
      pulse_cmd(6'b000100);
      wait_n(10);
      chk("pair reloaded", 32'(taken), 32'h6);
   endtask
   // ------------------------------------------------------------
   // verdict and run control
   // ------------------------------------------------------------
   task automatic conclude;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         conclude();
      end
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_masks();
      t_stack();
      t_halt();
      t_prio();
      t_pair();
      conclude();
   end
endmodule
`default_nettype wire
